// ===== rtl/lsct_pkg.sv
// constants shared by the lin synch trim block
package lsct_pkg;
  // synch field spans eight bit times, five falling edges
  localparam int          LSCT_SYNCH_BITS     = 8;
  localparam int          LSCT_SYNCH_EDGES    = 5;
  localparam int          LSCT_BAUD_OVERSAMP  = 16;
  localparam int          LSCT_EXP_MULT       = LSCT_SYNCH_BITS * LSCT_BAUD_OVERSAMP;
  localparam int          LSCT_CORR_NUM       = 250;
  localparam int          LSCT_CNT_W          = 8;
  localparam int          LSCT_MEAS_W         = 16;
  localparam int          LSCT_TRIM_W         = 8;
  // register map, byte addresses on the plain register port
  localparam logic [3:0]  LSCT_A_BAUD_LO      = 4'h0;
  localparam logic [3:0]  LSCT_A_BAUD_HI      = 4'h1;
  localparam logic [3:0]  LSCT_A_PRESCALE     = 4'h2;
  localparam logic [3:0]  LSCT_A_MIN_CORRECTION     = 4'h3;
  localparam logic [3:0]  LSCT_A_TRIM_UPPER   = 4'h4;
  localparam logic [3:0]  LSCT_A_TRIM_LOWER   = 4'h5;
  localparam logic [3:0]  LSCT_A_TRIM         = 4'h6;
  localparam logic [3:0]  LSCT_A_CTRL         = 4'h7;
  localparam logic [3:0]  LSCT_A_STATUS       = 4'h8;
  localparam logic [3:0]  LSCT_A_MEAS_LO      = 4'h9;
  localparam logic [3:0]  LSCT_A_MEAS_HI      = 4'hA;
  localparam logic [3:0]  LSCT_A_CORR         = 4'hB;
  // ctrl bits
  localparam int          LSCT_CTRL_EN        = 0;
  localparam int          LSCT_CTRL_PERMIT    = 1;
  // reset values, then the initial trim check window
  localparam logic [7:0]  LSCT_RST_BAUD_LO    = 8'h34;
  localparam logic [7:0]  LSCT_RST_BAUD_HI    = 8'h00;
  localparam logic [7:0]  LSCT_RST_PRESCALE   = 8'h20;
  localparam logic [7:0]  LSCT_RST_MIN_CORRECTION   = 8'h01;
  localparam logic [7:0]  LSCT_RST_TRIM_UPPER = 8'hF4;
  localparam logic [7:0]  LSCT_RST_TRIM_LOWER = 8'h0B;
  localparam logic [7:0]  LSCT_RST_TRIM       = 8'h80;
  localparam logic [7:0]  LSCT_TRIM_INIT_LO   = 8'h0A;
  localparam logic [7:0]  LSCT_TRIM_INIT_HI   = 8'hF5;
  // measurement sequencer
  typedef enum logic [3:0] {
    LSCT_IDLE  = 4'b0001,
    LSCT_ARMED = 4'b0010,
    LSCT_MEAS  = 4'b0100,
    LSCT_CALC  = 4'b1000
  } lsct_state_t;
endpackage : lsct_pkg

// ===== rtl/lsct_edge_sync.sv
// pin synchroniser with falling edge detect for the lin receive line
`timescale 1ns/10ps
`default_nettype none
module lsct_edge_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // pin in, edge out
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_fall
);
  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       fall;
  } lsct_sync_t;
  lsct_sync_t s_r, s_nxt;

  // a change is accepted only once stages two and three agree
  always_comb begin
    s_nxt      = s_r;
    s_nxt.sh   = {s_r.sh[1:0], i_pin};
    s_nxt.fall = 1'b0;
    if (s_r.sh[2] == s_r.sh[1] && s_r.sh[2] != s_r.lvl) begin
      s_nxt.lvl  = s_r.sh[2];
      s_nxt.fall = ~s_r.sh[2];
    end
  end

  // recessive line idles high
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) s_r <= '{sh: 3'b111, lvl: 1'b1, fall: 1'b0};
    else            s_r <= s_nxt;
  end

  assign o_level = s_r.lvl;
  assign o_fall  = s_r.fall;
endmodule : lsct_edge_sync
`default_nettype wire

// ===== rtl/lsct_trim.sv
// lin synch field measurement and oscillator trim correction
`timescale 1ns/10ps
`default_nettype none
module lsct_trim (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  // lin side
  input  wire logic                          i_lin_rx,
  input  wire logic                          i_break_rcvd,
  input  wire logic                          i_synch_rcvd,
  input  wire logic                          i_permit_tick,
  // register port
  input  wire logic [3:0]                    i_addr,
  input  wire logic [7:0]                    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [7:0]                    o_rdata,
  // oscillator trim and status
  output logic      [lsct_pkg::LSCT_TRIM_W-1:0] o_trim,
  output logic                               o_correction_direction,
  output logic                               o_apply_permit,
  output logic                               o_busy,
  output logic                               o_done
);
  import lsct_pkg::*;

  typedef struct packed {
    lsct_state_t              st;
    logic [7:0]               baud_lo;
    logic [7:0]               baud_hi;
    logic [7:0]               prescale;
    logic [7:0]               min_correction;
    logic [7:0]               trim_hi;
    logic [7:0]               trim_lo;
    logic [LSCT_TRIM_W-1:0]   trim;
    logic                     enable;
    logic                     permit;
    logic [7:0]               pre_cnt;
    logic [LSCT_CNT_W-1:0]    cnt;
    logic [LSCT_CNT_W-1:0]    first_cap;
    logic [7:0]               ovf;
    logic [2:0]               edges;
    logic [LSCT_MEAS_W-1:0]   meas;
    logic [7:0]               corr;
    logic                     dir;
    logic                     pending;
    logic                     done;
    logic                     busy;
    logic                     init_bad;
    logic [7:0]               rdata;
  } lsct_regs_t;
  lsct_regs_t r_r, r_nxt;

  logic rx_level;
  logic rx_fall;

  // three-stage pin sampling keeps metastability out of the capture
  lsct_edge_sync u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_lin_rx),
    .o_level   (rx_level),
    .o_fall    (rx_fall)
  );

  // expected count: 128 * divisor / prescale, integer truncation
  function automatic logic [LSCT_MEAS_W-1:0] exp_count(
    input logic [15:0] div,
    input logic [7:0]  pre
  );
    logic [31:0] num;
    num = 32'(div) * 32'(LSCT_EXP_MULT);
    if (pre == 8'h00) exp_count = '1;
    else              exp_count = LSCT_MEAS_W'(num / 32'(pre));
  endfunction : exp_count

  // saturating trim move inside the configured bounds
  function automatic logic [7:0] sat_trim(
    input logic [7:0] cur,
    input logic [7:0] step,
    input logic       up,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic [9:0] t;
    t = up ? {2'b00, cur} + {2'b00, step} : {2'b00, cur} - {2'b00, step};
    if (up && t > {2'b00, hi})             sat_trim = hi;
    else if (!up && (t[9] || t < {2'b00, lo})) sat_trim = lo;
    else                                   sat_trim = t[7:0];
  endfunction : sat_trim

  logic [LSCT_MEAS_W-1:0] expc;
  logic [LSCT_MEAS_W-1:0] diff;
  logic [31:0]            corr_full;
  logic [LSCT_MEAS_W-1:0] scale;
  logic                   tick;
  assign expc = exp_count({r_r.baud_hi, r_r.baud_lo}, r_r.prescale);
  // correction scale is an integer, so fractions are dropped
  assign scale = (expc == '0) ? '0 :
                 LSCT_MEAS_W'(32'(LSCT_CORR_NUM) / 32'(expc));
  assign diff = (r_r.meas > expc) ? r_r.meas - expc : expc - r_r.meas;
  assign corr_full = 32'(diff) * 32'(scale);
  // timer clock enable from the prescaler
  assign tick = (r_r.pre_cnt >= r_r.prescale - 8'h01) ||
                (r_r.prescale == 8'h00);

  always_comb begin
    r_nxt       = r_r;
    r_nxt.done  = 1'b0;
    r_nxt.rdata = 8'h00;

    // free running 8-bit timer on prescaled bus clock
    if (tick) begin
      r_nxt.pre_cnt = 8'h00;
      r_nxt.cnt     = r_r.cnt + 8'h01;
    end else begin
      r_nxt.pre_cnt = r_r.pre_cnt + 8'h01;
    end

    // periodic permit source; set wins over the clear on apply
    if (i_permit_tick) r_nxt.permit = 1'b1;

    // measurement sequencer
    case (r_r.st)
      LSCT_IDLE: begin
        if (r_r.enable && i_break_rcvd) r_nxt.st = LSCT_ARMED;
      end
      LSCT_ARMED: begin
        if (rx_fall) begin
          r_nxt.first_cap = r_r.cnt;
          r_nxt.ovf       = 8'h00;
          r_nxt.edges     = 3'd1;
          r_nxt.st        = LSCT_MEAS;
        end
      end
      LSCT_MEAS: begin
        // overflow is counted when the timer wraps past zero
        if (tick && r_r.cnt == 8'hFF) r_nxt.ovf = r_r.ovf + 8'h01;
        if (rx_fall) begin
          r_nxt.edges = r_r.edges + 3'd1;
          if (r_r.edges == 3'(LSCT_SYNCH_EDGES - 1)) begin
            // overflows*256 plus captured difference
            r_nxt.meas = {r_r.ovf, 8'h00} + 16'(r_r.cnt) -
                         16'(r_r.first_cap);
            r_nxt.st   = LSCT_CALC;
          end
        end
      end
      LSCT_CALC: begin
        // direction and magnitude from the finished count
        r_nxt.dir  = r_r.meas > expc;
        r_nxt.corr = (corr_full > 32'hFF) ? 8'hFF : corr_full[7:0];
        r_nxt.pending = (corr_full >= 32'(r_r.min_correction)) &&
                        (r_r.meas != expc);
        r_nxt.done = 1'b1;
        r_nxt.st   = LSCT_IDLE;
      end
      default: r_nxt.st = LSCT_IDLE;
    endcase

    // apply once the synch character is in, only with permit
    if (i_synch_rcvd && r_r.pending) begin
      r_nxt.pending = 1'b0;
      if (r_r.permit) begin
        r_nxt.trim = sat_trim(r_r.trim, r_r.corr, r_r.dir,
                              r_r.trim_hi, r_r.trim_lo);
        r_nxt.permit = i_permit_tick;
      end
    end

    // register writes
    if (i_wr) begin
      case (i_addr)
        LSCT_A_BAUD_LO:    r_nxt.baud_lo  = i_wdata;
        LSCT_A_BAUD_HI:    r_nxt.baud_hi  = i_wdata;
        LSCT_A_PRESCALE:   r_nxt.prescale = i_wdata;
        LSCT_A_MIN_CORRECTION:   r_nxt.min_correction = i_wdata;
        LSCT_A_TRIM_UPPER: r_nxt.trim_hi  = i_wdata;
        LSCT_A_TRIM_LOWER: r_nxt.trim_lo  = i_wdata;
        LSCT_A_TRIM: begin
          r_nxt.trim     = i_wdata;
          // initial trim must leave margin both ways
          r_nxt.init_bad = !(i_wdata > LSCT_TRIM_INIT_LO &&
                             i_wdata < LSCT_TRIM_INIT_HI);
        end
        LSCT_A_CTRL: begin
          r_nxt.enable = i_wdata[LSCT_CTRL_EN];
          if (i_wdata[LSCT_CTRL_PERMIT]) r_nxt.permit = 1'b1;
        end
        default: ;
      endcase
    end

    // register reads, data one cycle later
    if (i_rd) begin
      case (i_addr)
        LSCT_A_BAUD_LO:    r_nxt.rdata = r_r.baud_lo;
        LSCT_A_BAUD_HI:    r_nxt.rdata = r_r.baud_hi;
        LSCT_A_PRESCALE:   r_nxt.rdata = r_r.prescale;
        LSCT_A_MIN_CORRECTION:   r_nxt.rdata = r_r.min_correction;
        LSCT_A_TRIM_UPPER: r_nxt.rdata = r_r.trim_hi;
        LSCT_A_TRIM_LOWER: r_nxt.rdata = r_r.trim_lo;
        LSCT_A_TRIM:       r_nxt.rdata = r_r.trim;
        LSCT_A_CTRL:       r_nxt.rdata = {6'h00, r_r.permit, r_r.enable};
        LSCT_A_STATUS:     r_nxt.rdata = {2'h0, rx_level, r_r.init_bad,
                                          r_r.pending, r_r.dir,
                                          r_r.st != LSCT_IDLE,
                                          r_r.prescale <= r_r.baud_lo >> 1};
        LSCT_A_MEAS_LO:    r_nxt.rdata = r_r.meas[7:0];
        LSCT_A_MEAS_HI:    r_nxt.rdata = r_r.meas[15:8];
        LSCT_A_CORR:       r_nxt.rdata = r_r.corr;
        default:           r_nxt.rdata = 8'h00;
      endcase
    end

    // busy is registered so the output pin comes straight from a flop
    r_nxt.busy = (r_nxt.st != LSCT_IDLE);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_r          <= '0;
      r_r.st       <= LSCT_IDLE;
      r_r.baud_lo  <= LSCT_RST_BAUD_LO;
      r_r.baud_hi  <= LSCT_RST_BAUD_HI;
      r_r.prescale <= LSCT_RST_PRESCALE;
      r_r.min_correction <= LSCT_RST_MIN_CORRECTION;
      r_r.trim_hi  <= LSCT_RST_TRIM_UPPER;
      r_r.trim_lo  <= LSCT_RST_TRIM_LOWER;
      r_r.trim     <= LSCT_RST_TRIM;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_rdata                = r_r.rdata;
  assign o_trim                 = r_r.trim;
  assign o_correction_direction = r_r.dir;
  assign o_apply_permit         = r_r.permit;
  assign o_busy                 = r_r.busy;
  assign o_done                 = r_r.done;
endmodule : lsct_trim
`default_nettype wire

// ===== verification/lsct_trim_chk.sv
// assertion checker for the lin synch trim block
`timescale 1ns/10ps
`default_nettype none
module lsct_trim_chk
  import lsct_pkg::*;
(
  // clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_reset_n,
  // inputs watched
  input wire logic                   i_lin_rx,
  input wire logic                   i_break_rcvd,
  input wire logic                   i_synch_rcvd,
  input wire logic                   i_permit_tick,
  input wire logic [3:0]             i_addr,
  input wire logic [7:0]             i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  // outputs watched
  input wire logic [7:0]             o_rdata,
  input wire logic [LSCT_TRIM_W-1:0] o_trim,
  input wire logic                   o_correction_direction,
  input wire logic                   o_apply_permit,
  input wire logic                   o_busy,
  input wire logic                   o_done
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // completion is a single cycle strobe
  sequence s_done_pulse;
    o_done ##1 !o_done;
  endsequence
  // software writes may move the trim, so moves are judged without them
  property p_trim_hold;
    !i_synch_rcvd && !i_wr |=> $stable(o_trim);
  endproperty
  property p_trim_permit;
    $changed(o_trim) && !$past(i_wr) |-> $past(o_apply_permit);
  endproperty
  property p_permit_clear;
    $changed(o_trim) && !$past(i_wr) && !$past(i_permit_tick)
      |-> !o_apply_permit;
  endproperty
  property p_dir_sign;
    $changed(o_trim) && !$past(i_wr)
      |-> (o_trim > $past(o_trim)) == o_correction_direction;
  endproperty
  property p_tick;
    i_permit_tick |=> o_apply_permit;
  endproperty
  property p_done;
    o_done |-> s_done_pulse;
  endproperty
  property p_done_busy;
    o_done |-> $past(o_busy);
  endproperty
  property p_arm;
    !o_busy && !i_break_rcvd |=> !o_busy;
  endproperty
  property p_dir_change;
    $changed(o_correction_direction) |-> o_done;
  endproperty
  a_trim_hold: assert property (p_trim_hold)
    else $error("trim moved without synch");
  a_trim_permit: assert property (p_trim_permit)
    else $error("trim moved without permit");
  a_permit_clear: assert property (p_permit_clear)
    else $error("permit kept after apply");
  a_dir_sign: assert property (p_dir_sign)
    else $error("trim moved against direction");
  a_tick: assert property (p_tick)
    else $error("tick did not set permit");
  a_done: assert property (p_done)
    else $error("done longer than one cycle");
  a_done_busy: assert property (p_done_busy)
    else $error("done without measurement");
  a_arm: assert property (p_arm)
    else $error("busy without break");
  a_dir_change: assert property (p_dir_change)
    else $error("direction changed outside done");
endmodule : lsct_trim_chk
bind lsct_trim lsct_trim_chk u_lsct_trim_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_lin_rx(i_lin_rx),
  .i_break_rcvd(i_break_rcvd), .i_synch_rcvd(i_synch_rcvd),
  .i_permit_tick(i_permit_tick), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_trim(o_trim),
  .o_correction_direction(o_correction_direction),
  .o_apply_permit(o_apply_permit), .o_busy(o_busy), .o_done(o_done)
);
`default_nettype wire

// ===== verification/lsct_lin_master.sv
// lin master model sending break and synch field
`timescale 1ns/10ps
`default_nettype none
module lsct_lin_master (
  // clock
  input  wire logic i_clk,
  // bus line and receiver strobes
  output logic      o_lin,
  output logic      o_break_rcvd,
  output logic      o_synch_rcvd
);
  // line recessive at rest through the pull-up
  initial begin
    o_lin        = 1'h1;
    o_break_rcvd = 1'h0;
    o_synch_rcvd = 1'h0;
  end
  // break, delimiter, start, 0x55 lsb first, stop; bit_cyc clocks a bit
  task automatic send_header(input int bit_cyc);
    logic [23:0] pat;
    pat = {1'h1, 8'h55, 1'h0, 1'h1, 13'h0};
    for (int i = 0; i < 24; i++) begin
      @(posedge i_clk);
      o_lin        <= pat[i];
      o_break_rcvd <= (i == 13);
      @(posedge i_clk);
      o_break_rcvd <= 1'h0;
      repeat (bit_cyc - 2) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_synch_rcvd <= 1'h1;
    @(posedge i_clk);
    o_synch_rcvd <= 1'h0;
  endtask : send_header
endmodule : lsct_lin_master
`default_nettype wire

// ===== verification/lsct_trim_tb_top.sv
// self-checking bench for the lin synch trim block
`timescale 1ns/10ps
`default_nettype none
module lsct_trim_tb_top;
  import lsct_pkg::*;
  logic       i_clk         = 1'h0;
  logic       i_reset_n     = 1'h0;
  logic       i_permit_tick = 1'h0;
  logic [3:0] i_addr        = 4'h0;
  logic [7:0] i_wdata       = 8'h00;
  logic       i_wr          = 1'h0;
  logic       i_rd          = 1'h0;
  wire logic  i_lin_rx;
  wire logic  i_break_rcvd;
  wire logic  i_synch_rcvd;
  wire logic  [7:0] o_rdata;
  wire logic  [7:0] o_trim;
  wire logic  o_dir;
  wire logic  o_permit;
  wire logic  o_busy;
  wire logic  o_done;
  int         mismatches    = 0;
  int         tests_run     = 0;
  // reset values of addresses 0 to 6
  logic [7:0] rst_tab [7] = '{LSCT_RST_BAUD_LO, LSCT_RST_BAUD_HI,
    LSCT_RST_PRESCALE, LSCT_RST_MIN_CORRECTION, LSCT_RST_TRIM_UPPER,
    LSCT_RST_TRIM_LOWER, LSCT_RST_TRIM};
  always #5 i_clk = ~i_clk;
  lsct_trim u_lsct_trim (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_lin_rx(i_lin_rx),
    .i_break_rcvd(i_break_rcvd), .i_synch_rcvd(i_synch_rcvd),
    .i_permit_tick(i_permit_tick), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_trim(o_trim),
    .o_correction_direction(o_dir), .o_apply_permit(o_permit),
    .o_busy(o_busy), .o_done(o_done));
  lsct_lin_master u_lsct_lin_master (.i_clk(i_clk), .o_lin(i_lin_rx),
    .o_break_rcvd(i_break_rcvd), .o_synch_rcvd(i_synch_rcvd));
  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'h1;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'h1;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1 check(what, o_rdata, exp);
  endtask : rd
  task automatic hdr(input int b);
    u_lsct_lin_master.send_header(b);
    repeat (4) @(posedge i_clk);
  endtask : hdr
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // watchdog: the tests need about 43k cycles
  initial begin
    #800000;
    mismatches++;
    results();
  end
  // divisor 16, prescale 16: expected 128 ticks, scale 1
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'h1;
    check("trim", o_trim, 8'h80);
    check("busy", o_busy, 1'h0);
    check("done", o_done, 1'h0);
    for (int a = 0; a < 7; a++) rd(a[3:0], rst_tab[a], "reset");
    wr(4'hC, 8'hFF);
    rd(4'hC, 8'h00, "unmapped");
    $display("test reset done");
    wr(LSCT_A_BAUD_LO, 8'h10);
    wr(LSCT_A_PRESCALE, 8'h10);
    wr(LSCT_A_CTRL, 8'h01);
    hdr(264);
    rd(LSCT_A_MEAS_LO, 8'h84, "meas");
    rd(LSCT_A_CORR, 8'h04, "corr");
    check("dir", o_dir, 1'h1);
    check("trim", o_trim, 8'h80);
    check("busy", o_busy, 1'h0);
    check("done", o_done, 1'h0);
    $display("test no permit done");
    @(posedge i_clk);
    i_permit_tick <= 1'h1;
    @(posedge i_clk);
    i_permit_tick <= 1'h0;
    hdr(264);
    check("trim", o_trim, 8'h84);
    check("permit", o_permit, 1'h0);
    wr(LSCT_A_CTRL, 8'h03);
    hdr(248);
    check("dir", o_dir, 1'h0);
    check("trim", o_trim, 8'h80);
    $display("test apply done");
    wr(LSCT_A_MIN_CORRECTION, 8'h05);
    wr(LSCT_A_CTRL, 8'h03);
    hdr(264);
    check("trim", o_trim, 8'h80);
    check("permit", o_permit, 1'h1);
    wr(LSCT_A_MIN_CORRECTION, 8'h01);
    hdr(512);
    rd(LSCT_A_MEAS_HI, 8'h01, "meas_hi");
    rd(LSCT_A_MEAS_LO, 8'h00, "meas_lo");
    check("trim", o_trim, 8'hF4);
    wr(LSCT_A_TRIM, 8'h0C);
    wr(LSCT_A_CTRL, 8'h03);
    hdr(248);
    check("trim", o_trim, 8'h0B);
    $display("test bounds done");
    wr(LSCT_A_TRIM, 8'h05);
    rd(LSCT_A_STATUS, 8'h30, "status");
    $display("test init done");
    results();
  end
endmodule : lsct_trim_tb_top
`default_nettype wire
